// ### logic/catb_pkg.sv
// Shared constants, types and helpers for the counter array timebase and interrupt block.
// Assumes one system clock at 200 MHz and an active-low asynchronous reset.
//
// Notes on behaviour
// - Counter is one 16-bit value held as a high byte and a low byte.
// - Reading the low byte copies the high byte into a snapshot for the next high read.
// - Reads never pause, reset or disturb counting.
// - Timebase 000 sysclk/12, 001 sysclk/4, 010 timer 0 overflow, 100 sysclk.
// - Timebase 011 counts falling edges of the count pin, at most one per four clocks.
// - Timebase 101 counts synchronised external oscillator divided by 8; 11x reserved.
// - Wrap from all ones to zero sets the overflow flag.
// - Overflow flag requests an interrupt only while its enable is one.
// - Overflow flag is never cleared by vectoring; software clears it.
// - With idle suspend at zero, counting continues while the processor idles.
// - Five capture/compare modules, each line reaches its pin only when enabled.
// - Six independent flags: overflow plus one event flag per module.
// - Every flag sets on its trigger whatever its interrupt enable holds.
// - Interrupt request is the OR of each flag gated by its own enable.
// - Every reset enables module 4 as a watchdog.
// - While the watchdog is enabled, access to some registers is refused.
// - Bit 0 of each module mode register is that module's interrupt enable.
// - Module flags are never cleared by vectoring; software clears them.

package catb_pkg;

   localparam int CNT_W   = 16;
   localparam int BYTE_W  = 8;
   localparam int NUM_MOD = 5;
   localparam int TB_W    = 3;

   localparam logic [TB_W-1:0] TB_DIV12 = 3'h0;
   localparam logic [TB_W-1:0] TB_DIV4  = 3'h1;
   localparam logic [TB_W-1:0] TB_T0OVF = 3'h2;
   localparam logic [TB_W-1:0] TB_PINFALL = 3'h3;
   localparam logic [TB_W-1:0] TB_SYS   = 3'h4;
   localparam logic [TB_W-1:0] TB_OSC8  = 3'h5;

   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [1:0] DIV4_LAST  = 2'h3;
   localparam logic [2:0] OSC8_LAST  = 3'h7;
   localparam logic [1:0] PIN_GAP_LAST = 2'h3;

   localparam int              MODE_IRQ_EN_BIT = 0;
   localparam int              WDT_MODULE      = 4;
   localparam logic [CNT_W-1:0] CNT_RST        = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ALL_ONES   = 16'hffff;
   localparam logic [TB_W-1:0]  TB_RST         = 3'h0;

   typedef enum logic [1:0] {
      CATB_WDT_ON  = 2'b01,
      CATB_WDT_OFF = 2'b10
   } catb_wdt_state_t;

   typedef struct packed {
      logic [TB_W-1:0] timebase_select;
      logic            idle_suspend;
      logic            overflow_irq_enable;
   } catb_cfg_t;

   typedef struct packed {
      logic              rd_low;
      logic              rd_high;
      logic              wr_low;
      logic              wr_high;
      logic [BYTE_W-1:0] wr_data;
   } catb_access_t;

   function automatic logic catb_gate(input logic [NUM_MOD:0] flags,
                                      input logic [NUM_MOD:0] enables);
      catb_gate = |(flags & enables);
   endfunction

endpackage

// ### logic/catb_tick_gen.sv
// Count source selection for the counter array: one-cycle advance pulses.
// Assumes the pin inputs are synchronous to sys_clk except the external oscillator.

`timescale 1ns/1ps
`default_nettype none

module catb_tick_gen (
   input  wire logic                      sys_clk,
   input  wire logic                      nrst,
   input  wire logic [catb_pkg::TB_W-1:0] timebase_select,
   input  wire logic                      timer0_overflow,
   input  wire logic                      external_count_input,
   input  wire logic                      ext_osc,
   output logic                           tick
);

   // ************************************************
   // Dividers and edge detectors
   // ************************************************
   logic [3:0] div12;
   logic [1:0] div4;
   logic [2:0] osc8;
   logic [1:0] pin_gap;
   logic       pin_prev;
   logic       osc_s1;
   logic       osc_s2;
   logic       osc_s3;

   wire logic div12_hit = (div12 == catb_pkg::DIV12_LAST);
   wire logic div4_hit  = (div4 == catb_pkg::DIV4_LAST);
   wire logic pin_fall  = pin_prev & ~external_count_input & (pin_gap == 2'h0);
   wire logic osc_rise  = osc_s2 & ~osc_s3;
   wire logic osc8_hit  = osc_rise & (osc8 == catb_pkg::OSC8_LAST);

   logic next_tick;
   always_comb begin
      case (timebase_select)
         catb_pkg::TB_DIV12:   next_tick = div12_hit;
         catb_pkg::TB_DIV4:    next_tick = div4_hit;
         catb_pkg::TB_T0OVF:   next_tick = timer0_overflow;
         catb_pkg::TB_PINFALL: next_tick = pin_fall;
         catb_pkg::TB_SYS:     next_tick = 1'b1;
         catb_pkg::TB_OSC8:    next_tick = osc8_hit;
         default:              next_tick = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         div12 <= 4'h0;
         div4 <= 2'h0;
      end else begin
         div12 <= div12_hit ? 4'h0 : div12 + 4'h1;
         div4 <= div4 + 2'h1;
      end
   end

   // A recognised fall blocks further ones for three clocks, so the rate stays at sysclk/4.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_prev <= 1'b1;
         pin_gap <= 2'h0;
      end else begin
         pin_prev <= external_count_input;
         if (pin_fall) begin
            pin_gap <= catb_pkg::PIN_GAP_LAST;
         end else if (pin_gap != 2'h0) begin
            pin_gap <= pin_gap - 2'h1;
         end
      end
   end

   // The oscillator is asynchronous; only osc_s2 and later stages feed logic.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
         osc8 <= 3'h0;
      end else begin
         osc_s1 <= ext_osc;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
         if (osc_rise) begin
            osc8 <= osc8 + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tick <= 1'b0;
      end else begin
         tick <= next_tick;
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   a_pin_rate_limit: assert property (@(posedge sys_clk) disable iff (!nrst)
      (pin_fall && timebase_select == catb_pkg::TB_PINFALL) |=> ##1 !tick[*3])
      else $error("count pin ticks closer than four clocks");

endmodule // catb_tick_gen

`default_nettype wire

// ### logic/catb_counter_array.sv
// Counter array 16-bit counter, overflow and module event flags, interrupt request, watchdog lock.
// Assumes host access strobes are one-cycle pulses synchronous to sys_clk.

`timescale 1ns/1ps
`default_nettype none

module catb_counter_array (
   input  wire logic                                    sys_clk,
   input  wire logic                                    nrst,
   input  wire catb_pkg::catb_access_t                  host_access,
   input  wire logic                                    cfg_write,
   input  wire catb_pkg::catb_cfg_t                     array_mode_register,
   input  wire logic                                    watchdog_disable,
   input  wire logic                                    clear_overflow_flag,
   input  wire logic [catb_pkg::NUM_MOD-1:0]            clear_module_flag,
   input  wire logic [catb_pkg::NUM_MOD-1:0]            module_event,
   input  wire logic [catb_pkg::NUM_MOD-1:0][7:0]       module_mode_register,
   input  wire logic [catb_pkg::NUM_MOD-1:0]            module_line_drive,
   input  wire logic [catb_pkg::NUM_MOD-1:0]            module_line_enable,
   input  wire logic                                    cpu_idle,
   input  wire logic                                    timer0_overflow,
   input  wire logic                                    external_count_input,
   input  wire logic                                    ext_osc,
   output logic [catb_pkg::CNT_W-1:0]                   count_value,
   output logic [catb_pkg::BYTE_W-1:0]                  read_data,
   output logic                                         read_valid,
   output catb_pkg::catb_cfg_t                          mode_readback,
   output logic                                         count_overflow_flag,
   output logic [catb_pkg::NUM_MOD-1:0]                 module_event_flag,
   output logic                                         irq_request,
   output logic                                         watchdog_active,
   output logic                                         access_refused,
   output logic [catb_pkg::NUM_MOD-1:0]                 module_io_line,
   output logic [catb_pkg::NUM_MOD-1:0]                 module_io_line_oe_n
);

   // ************************************************
   // Watchdog lock
   // ************************************************
   catb_pkg::catb_wdt_state_t wdt_state;
   catb_pkg::catb_wdt_state_t next_wdt_state;

   wire logic wdt_on = (wdt_state == catb_pkg::CATB_WDT_ON);

   always_comb begin
      case (wdt_state)
         catb_pkg::CATB_WDT_ON: begin
            next_wdt_state = watchdog_disable ? catb_pkg::CATB_WDT_OFF
                                              : catb_pkg::CATB_WDT_ON;
         end
         catb_pkg::CATB_WDT_OFF: next_wdt_state = catb_pkg::CATB_WDT_OFF;
         default:                next_wdt_state = catb_pkg::CATB_WDT_ON;
      endcase
   end

   // Only a reset turns the watchdog back on, so a runaway program cannot unlock and relock it.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wdt_state <= catb_pkg::CATB_WDT_ON;
      end else begin
         wdt_state <= next_wdt_state;
      end
   end

   // ************************************************
   // Configuration
   // ************************************************
   catb_pkg::catb_cfg_t cfg;

   wire logic wr_low_ok   = host_access.wr_low & ~wdt_on;
   wire logic wr_high_ok  = host_access.wr_high & ~wdt_on;
   wire logic cfg_wr_ok   = cfg_write & ~wdt_on;
   wire logic any_refused = wdt_on & (host_access.wr_low | host_access.wr_high | cfg_write);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= '{timebase_select: catb_pkg::TB_RST, idle_suspend: 1'b0,
                  overflow_irq_enable: 1'b0};
      end else if (cfg_wr_ok) begin
         cfg <= array_mode_register;
      end
   end

   // ************************************************
   // Timebase
   // ************************************************
   logic tick;

   catb_tick_gen u_tick_gen (
      .sys_clk              (sys_clk),
      .nrst                 (nrst),
      .timebase_select      (cfg.timebase_select),
      .timer0_overflow      (timer0_overflow),
      .external_count_input (external_count_input),
      .ext_osc              (ext_osc),
      .tick                 (tick)
   );

   // ************************************************
   // Counter and snapshot
   // ************************************************
   logic [catb_pkg::CNT_W-1:0]  count;
   logic [catb_pkg::BYTE_W-1:0] snapshot;

   wire logic idle_hold = cpu_idle & cfg.idle_suspend;
   wire logic advance   = tick & ~idle_hold & ~wr_low_ok & ~wr_high_ok;
   wire logic wrap      = advance & (count == catb_pkg::CNT_ALL_ONES);

   logic [catb_pkg::CNT_W-1:0] next_count;
   always_comb begin
      if (wr_low_ok) begin
         next_count = {count[15:8], host_access.wr_data};
      end else if (wr_high_ok) begin
         next_count = {host_access.wr_data, count[7:0]};
      end else if (advance) begin
         next_count = count + 16'h0001;
      end else begin
         next_count = count;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count <= catb_pkg::CNT_RST;
      end else begin
         count <= next_count;
      end
   end

   // Reads only touch the snapshot and the read port, never the counter itself.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         snapshot <= 8'h00;
         read_data <= 8'h00;
         read_valid <= 1'b0;
      end else begin
         read_valid <= host_access.rd_low | host_access.rd_high;
         if (host_access.rd_low) begin
            snapshot <= count[15:8];
            read_data <= count[7:0];
         end else if (host_access.rd_high) begin
            read_data <= snapshot;
         end
      end
   end

   // ************************************************
   // Event flags and interrupt request
   // ************************************************
   logic [catb_pkg::NUM_MOD-1:0] module_irq_enable;
   always_comb begin
      for (int i = 0; i < catb_pkg::NUM_MOD; i++) begin
         module_irq_enable[i] = module_mode_register[i][catb_pkg::MODE_IRQ_EN_BIT];
      end
   end

   // Set wins over a clear in the same cycle so no event is dropped.
   wire logic next_ovf = wrap | (count_overflow_flag & ~clear_overflow_flag);
   wire logic [catb_pkg::NUM_MOD-1:0] next_mod_flag =
      module_event | (module_event_flag & ~clear_module_flag);

   wire logic next_irq = catb_pkg::catb_gate({next_mod_flag, next_ovf},
                                            {module_irq_enable, cfg.overflow_irq_enable});

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count_overflow_flag <= 1'b0;
         module_event_flag <= 5'h00;
         irq_request <= 1'b0;
      end else begin
         count_overflow_flag <= next_ovf;
         module_event_flag <= next_mod_flag;
         irq_request <= next_irq;
      end
   end

   // ************************************************
   // Module lines and status outputs
   // ************************************************
   wire logic [catb_pkg::NUM_MOD-1:0] line_on = module_line_enable;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         module_io_line <= 5'h00;
         module_io_line_oe_n <= 5'h1f;
      end else begin
         module_io_line <= module_line_drive & line_on;
         module_io_line_oe_n <= ~line_on;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count_value <= catb_pkg::CNT_RST;
         mode_readback <= '{timebase_select: catb_pkg::TB_RST, idle_suspend: 1'b0,
                            overflow_irq_enable: 1'b0};
         watchdog_active <= 1'b1;
         access_refused <= 1'b0;
      end else begin
         count_value <= next_count;
         mode_readback <= cfg_wr_ok ? array_mode_register : cfg;
         watchdog_active <= (next_wdt_state == catb_pkg::CATB_WDT_ON);
         access_refused <= any_refused;
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_low_read;
      host_access.rd_low;
   endsequence

   a_snapshot_latch: assert property (
      s_low_read |=> snapshot == $past(count[15:8]))
      else $error("low read did not latch the high byte");

   a_high_from_snap: assert property (
      (host_access.rd_high && !host_access.rd_low) |=> read_data == $past(snapshot))
      else $error("high read returned something other than the snapshot");

   a_read_no_stall: assert property (
      (host_access.rd_low || host_access.rd_high) && advance |=> count == $past(count) + 16'h0001)
      else $error("a read disturbed counting");

   a_overflow_sets: assert property (
      wrap |=> count_overflow_flag && count == 16'h0000)
      else $error("wrap did not set the overflow flag");

   a_flag_sticky: assert property (
      count_overflow_flag && !clear_overflow_flag |=> count_overflow_flag)
      else $error("overflow flag dropped without a clear");

   a_idle_hold: assert property (
      idle_hold && !wr_low_ok && !wr_high_ok |=> count == $past(count))
      else $error("counter moved while idle suspended");

   a_idle_runs: assert property (
      cpu_idle && tick && !cfg.idle_suspend && !host_access.wr_low && !host_access.wr_high
      |=> count != $past(count))
      else $error("counter stopped during idle with suspend off");

   a_event_sets: assert property (
      |module_event |=> (module_event_flag & $past(module_event)) == $past(module_event))
      else $error("module event did not set its flag");

   a_irq_gating: assert property (
      irq_request |-> (count_overflow_flag && $past(cfg.overflow_irq_enable))
                      || |(module_event_flag & $past(module_irq_enable)))
      else $error("interrupt request without an enabled flag");

   a_wdt_blocks: assert property (
      wdt_on && (host_access.wr_low || host_access.wr_high) && !advance
      |=> access_refused && count == $past(count))
      else $error("counter write accepted while watchdog on");

   a_wdt_after_rst: assert property (
      wdt_on && !watchdog_disable |=> wdt_on && watchdog_active)
      else $error("watchdog left enabled state without a disable");

endmodule // catb_counter_array

`default_nettype wire

// ### dv/catb_cpu_model.sv
// Processor-side model for the counter array: takes the interrupt request.
// Assumes irq_request is a registered level on sys_clk; enables come from the bench.

`timescale 1ns/1ps
`default_nettype none

module catb_cpu_model (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        irq_request,
   input  wire logic        global_irq_enable,
   input  wire logic        array_irq_enable,
   output logic [15:0]      n_vectors
);
   // ******************************
   // Interrupt acceptance
   // ******************************
   // Vectoring leaves every flag alone, so a level request keeps vectoring
   // until the service code clears the flag itself.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         n_vectors <= 16'h0000;
      end else if (irq_request && global_irq_enable && array_irq_enable) begin
         n_vectors <= n_vectors + 16'h0001;
      end
   end
endmodule // catb_cpu_model

`default_nettype wire

// ### dv/counter_array_timebase_irq_bench.sv
// Self-checking bench for catb_counter_array with a processor-side model.
// Assumes a 200 MHz sys_clk and that ext_osc is unrelated in phase to it.

`timescale 1ns/1ps
`default_nettype none

module counter_array_timebase_irq_bench;
   // ******************************
   // Stimulus and wiring
   // ******************************
   logic                   sys_clk = 1'b0;
   logic                   nrst = 1'b0;
   catb_pkg::catb_access_t host_access = '0;
   catb_pkg::catb_cfg_t    array_mode_register = '0;
   catb_pkg::catb_cfg_t    mode_readback;
   logic                   cfg_write = 1'b0, watchdog_disable = 1'b0;
   logic                   clear_overflow_flag = 1'b0, timer0_overflow = 1'b0;
   logic                   cpu_idle = 1'b0, external_count_input = 1'b1, ext_osc = 1'b0;
   logic                   ge = 1'b0, ae = 1'b1;
   logic [4:0]             clear_module_flag = '0, module_event = '0;
   logic [4:0]             module_line_drive = '0, module_line_enable = '0;
   logic [4:0][7:0]        module_mode_register = '0;
   logic [15:0]            count_value, n_vectors;
   logic [7:0]             read_data;
   logic                   read_valid, count_overflow_flag, irq_request;
   logic                   watchdog_active, access_refused;
   logic [4:0]             module_event_flag, module_io_line, module_io_line_oe_n;
   int                     n_errors = 0, n_checks = 0, cyc = 0, refused = 0;

   catb_counter_array u_dut (.sys_clk, .nrst, .host_access, .cfg_write,
      .array_mode_register, .watchdog_disable, .clear_overflow_flag, .clear_module_flag,
      .module_event, .module_mode_register, .module_line_drive, .module_line_enable,
      .cpu_idle, .timer0_overflow, .external_count_input, .ext_osc, .count_value,
      .read_data, .read_valid, .mode_readback, .count_overflow_flag, .module_event_flag,
      .irq_request, .watchdog_active, .access_refused, .module_io_line,
      .module_io_line_oe_n);

   catb_cpu_model u_cpu (.sys_clk, .nrst, .irq_request, .global_irq_enable(ge),
      .array_irq_enable(ae), .n_vectors);

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // The oscillator half period is deliberately not a multiple of the clock.
   initial begin
      forever #7.3 ext_osc = ~ext_osc;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (access_refused === 1'b1) begin
         refused <= refused + 1;
      end
   end

   // ******************************
   // Tasks and expectations
   // ******************************
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   function automatic logic [15:0] exp_ticks(input logic [2:0] tb, input int n);
      case (tb)
         catb_pkg::TB_SYS:   exp_ticks = 16'(n);
         catb_pkg::TB_DIV4:  exp_ticks = 16'(n / 4);
         catb_pkg::TB_DIV12: exp_ticks = 16'(n / 12);
         default:            exp_ticks = 16'h0000;
      endcase
   endfunction
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic delta(input int n, input logic [15:0] exp);
      logic [15:0] c0;
      c0 = count_value;
      wait_n(n);
      chk(count_value - c0, exp);
   endtask
   task automatic acc(input logic [3:0] s, input logic [7:0] d);
      @(posedge sys_clk);
      host_access <= catb_pkg::catb_access_t'({s, d});
      @(posedge sys_clk);
      host_access <= '0;
   endtask
   task automatic rd(input logic low, output logic [7:0] d);
      acc({low, ~low, 2'b00}, 8'h00);
      #1;
      chk(read_valid, 16'h0001);
      d = read_data;
   endtask
   task automatic wr16(input logic [15:0] v);
      acc(4'b0010, v[7:0]);
      acc(4'b0001, v[15:8]);
      wait_n(1);
   endtask
   task automatic cfg(input logic [2:0] tb, input logic sus, input logic oie);
      @(posedge sys_clk);
      array_mode_register <= '{tb, sus, oie};
      cfg_write <= 1'b1;
      @(posedge sys_clk);
      cfg_write <= 1'b0;
      wait_n(4);
   endtask
   task automatic pulse(input int sel, input logic [4:0] m);
      @(posedge sys_clk);
      case (sel)
         0: timer0_overflow <= 1'b1;
         1: clear_overflow_flag <= 1'b1;
         2: module_event <= m;
         3: clear_module_flag <= m;
         default: watchdog_disable <= 1'b1;
      endcase
      @(posedge sys_clk);
      {timer0_overflow, clear_overflow_flag, watchdog_disable} <= 3'h0;
      module_event <= '0;
      clear_module_flag <= '0;
   endtask
   task automatic pin_falls(input int half, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         external_count_input <= 1'b0;
         repeat (half) @(posedge sys_clk);
         external_count_input <= 1'b1;
         repeat (half - 1) @(posedge sys_clk);
      end
      wait_n(6);
   endtask

   initial begin
      #100us;
      n_errors++;
      finish_test();
   end

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      logic [7:0] d, e, f, lo, hi;
      logic [15:0] c0, v;
      logic en;
      logic [2:0] tbs[5] = '{3'h4, 3'h1, 3'h0, 3'h6, 3'h7};
      void'($urandom(73));
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      wait_n(1);
      chk(watchdog_active, 16'h0001);
      chk({11'h000, module_io_line_oe_n}, 16'h001f);
      acc(4'b0001, 8'ha5);
      cfg(catb_pkg::TB_SYS, 1'b0, 1'b0);
      chk(count_value[15:8], 16'h0000);
      chk(mode_readback, 16'h0000);
      chk(16'(refused), 16'h0002);
      pulse(4, 5'h00);
      wait_n(2);
      chk(watchdog_active, 16'h0000);
      $display("test watchdog done");
      foreach (tbs[i]) begin
         cfg(tbs[i], 1'b0, 1'b0);
         delta(48, exp_ticks(tbs[i], 48));
      end
      cfg(catb_pkg::TB_T0OVF, 1'b0, 1'b0);
      c0 = count_value;
      repeat (5) begin
         pulse(0, 5'h00);
         wait_n($urandom_range(1, 6));
      end
      wait_n(4);
      chk(count_value - c0, 16'h0005);
      cfg(catb_pkg::TB_PINFALL, 1'b0, 1'b0);
      c0 = count_value;
      pin_falls(4, 6);
      chk(count_value - c0, 16'h0006);
      c0 = count_value;
      pin_falls(1, 20);
      chk_rng(count_value - c0, 16'h0009, 16'h000b);
      cfg(catb_pkg::TB_OSC8, 1'b0, 1'b0);
      c0 = count_value;
      wait_n(234);
      chk_rng(count_value - c0, 16'h0009, 16'h000b);
      $display("test timebase done");
      cfg(catb_pkg::TB_T0OVF, 1'b0, 1'b0);
      d = 8'($urandom);
      e = 8'($urandom);
      f = ~e;
      wr16({e, d});
      chk(count_value, {e, d});
      rd(1'b1, lo);
      chk(lo, d);
      acc(4'b0001, f);
      rd(1'b0, hi);
      chk(hi, e);
      rd(1'b1, lo);
      rd(1'b0, hi);
      chk(hi, f);
      wr16(16'h12f8);
      cfg(catb_pkg::TB_SYS, 1'b0, 1'b0);
      c0 = count_value;
      e = 8'(cyc);
      rd(1'b1, lo);
      rd(1'b0, hi);
      v = count_value;
      chk(v - c0, {8'h00, 8'(cyc) - e});
      chk_rng({hi, lo}, c0, v);
      $display("test reads done");
      cfg(catb_pkg::TB_T0OVF, 1'b0, 1'b0);
      wr16(16'hffff);
      pulse(0, 5'h00);
      wait_n(4);
      chk(count_value, 16'h0000);
      chk(count_overflow_flag, 16'h0001);
      chk(irq_request, 16'h0000);
      cfg(catb_pkg::TB_T0OVF, 1'b0, 1'b1);
      chk(irq_request, 16'h0001);
      v = n_vectors;
      wait_n(4);
      chk(n_vectors, v);
      @(posedge sys_clk);
      ge <= 1'b1;
      wait_n(4);
      chk_rng(n_vectors - v, 16'h0001, 16'hffff);
      chk(count_overflow_flag, 16'h0001);
      pulse(1, 5'h00);
      wait_n(2);
      chk(irq_request, 16'h0000);
      $display("test overflow done");
      for (int i = 0; i < 5; i++) begin
         en = (i < 2) ? i[0] : 1'($urandom);
         @(posedge sys_clk);
         module_mode_register[i] <= {7'($urandom), en};
         pulse(2, 5'h01 << i);
         wait_n(8);
         chk({11'h000, module_event_flag}, 16'(5'h01 << i));
         chk(irq_request, 16'(en));
         pulse(3, 5'h01 << i);
         wait_n(2);
         chk({11'h000, module_event_flag}, 16'h0000);
      end
      $display("test module flags done");
      cfg(catb_pkg::TB_SYS, 1'b0, 1'b0);
      @(posedge sys_clk);
      cpu_idle <= 1'b1;
      wait_n(3);
      delta(20, 16'h0014);
      cfg(catb_pkg::TB_SYS, 1'b1, 1'b0);
      delta(20, 16'h0000);
      @(posedge sys_clk);
      cpu_idle <= 1'b0;
      wait_n(3);
      delta(20, 16'h0014);
      $display("test idle done");
      repeat (4) begin
         @(posedge sys_clk);
         module_line_drive <= 5'($urandom);
         module_line_enable <= 5'($urandom);
         wait_n(3);
         chk({11'h000, module_io_line_oe_n}, {11'h000, ~module_line_enable});
         chk(16'(module_io_line), 16'(module_line_drive & module_line_enable));
      end
      $display("test lines done");
      // A second reset in mid-run must bring the watchdog lock back and clear the counter.
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      wait_n(1);
      chk(watchdog_active, 16'h0001);
      chk(count_value, 16'h0000);
      $display("test reset done");
      finish_test();
   end
endmodule // counter_array_timebase_irq_bench

`default_nettype wire
